// ===== hdl/unified_write_through_cache.sv
`timescale 1ns/1ps
`include "cache_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - one 1 KByte unified write-through cache
// - allocate lines only on read misses
// - selectable direct-mapped or two-way placement
// - direct-mapped: 256 four-byte lines
// - two-way: two ways of 128 lines
// - two-way victim chosen by per-pair LRU
// - single-cycle 32-bit access for read hits
// - writes posted through two-entry buffer
// - execution continues once write posted
// - hits answered without external bus access
// - tags cover full 32-bit physical address
// - reset invalidates lines, enable taken from cacheEn input
module unified_write_through_cache (
  input wire logic clk,
  input wire logic rst,
  input wire logic cacheEn,
  input wire logic twoWay,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [31:0] reqAddr,
  input wire logic [3:0] reqByteEn,
  input wire logic [31:0] reqWdata,
  output logic reqReady,
  output logic rspValid,
  output logic [31:0] rspData,
  output logic busRdReq,
  output logic [31:0] busRdAddr,
  input wire logic busRdDone,
  input wire logic [31:0] busRdData,
  output logic busWrValid,
  output logic [31:0] busWrAddr,
  output logic [3:0] busWrByteEn,
  output logic [31:0] busWrData,
  input wire logic busWrDone
);
  localparam int LINES = `DM_LINES;
  localparam int DEPTH = `WBUF_DEPTH;

  // storage: entries 0..127 way 0, 128..255 way 1 in two-way mode
  logic [31:0] dataMem [LINES];
  logic [31:0] tagMem [LINES];
  logic [LINES-1:0] valid_q;
  logic [`TW_LINES-1:0] lru_q;
  cache_pkg::state_t state_q;
  logic [31:0] wbAddr [DEPTH];
  logic [31:0] wbData [DEPTH];
  logic [3:0] wbBe [DEPTH];
  logic wbHead_q, wbTail_q;
  logic [1:0] wbCount_q;
  logic reqReady_q, rspValid_q, busRdReq_q, busWrValid_q;
  logic [31:0] rspData_q, busRdAddr_q, busWrAddr_q, busWrData_q, fillAddr_q;
  logic [3:0] busWrByteEn_q;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    for (int i = 0; i < `LINE_BYTES; i++) begin
      if (be[i]) o[i*8 +: 8] = n[i*8 +: 8];
    end
    return o;
  endfunction : merge

  function automatic logic [7:0] slot(input logic tw, input logic way, input logic [31:0] a);
    return tw ? {way, a[`OFS_BITS +: `IDX_TW_BITS]} : a[`OFS_BITS +: `IDX_DM_BITS];
  endfunction : slot

  ////////////////////////////////////////////////////////////////////////////////
  // lookup
  wire [7:0] slot0 = slot(twoWay, 1'b0, reqAddr);
  wire [7:0] slot1 = slot(twoWay, 1'b1, reqAddr);
  wire [6:0] pairIdx = reqAddr[`OFS_BITS +: `IDX_TW_BITS];
  wire hit0 = valid_q[slot0] && tagMem[slot0] == reqAddr;
  wire hit1 = twoWay && valid_q[slot1] && tagMem[slot1] == reqAddr;
  wire hit = cacheEn && (hit0 || hit1);
  wire [7:0] hitSlot = hit1 ? slot1 : slot0;
  wire wbFull = wbCount_q == 2'(DEPTH);
  wire idle = state_q == cache_pkg::IDLE;
  wire take = reqValid && reqReady_q;
  wire doWrite = take && reqWrite;
  wire doReadHit = take && !reqWrite && hit;
  wire doReadMiss = take && !reqWrite && !hit;
  wire drain = busWrValid_q && busWrDone;
  wire [7:0] fill0 = slot(twoWay, 1'b0, fillAddr_q);
  wire [7:0] fill1 = slot(twoWay, 1'b1, fillAddr_q);
  wire [6:0] fillPair = fillAddr_q[`OFS_BITS +: `IDX_TW_BITS];
  wire victimWay = twoWay && (valid_q[fill0] ? (valid_q[fill1] ? ~lru_q[fillPair] : 1'b1)
                                              : 1'b0);
  wire [7:0] fillSlot = victimWay ? fill1 : fill0;
  wire fillDone = !idle && busRdDone;
  wire [1:0] wbCount_d = 2'(wbCount_q + (doWrite ? 2'h1 : 2'h0) - (drain ? 2'h1 : 2'h0));
  wire nextReady = (state_q == cache_pkg::IDLE && !doReadMiss) || fillDone;
  wire [1:0] nextCount = wbCount_d;
  wire reqReady_d = nextReady && nextCount != 2'(DEPTH);
  wire [1:0] headAfter = {1'b0, wbHead_q ^ drain};
  wire wbHasAfter = wbCount_d != 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // arrays
  always_ff @(posedge clk) begin
    if (doWrite && hit) dataMem[hitSlot] <= merge(dataMem[hitSlot], reqWdata, reqByteEn);
    if (fillDone && cacheEn) begin
      dataMem[fillSlot] <= busRdData;
      tagMem[fillSlot] <= fillAddr_q;
    end
    if (doWrite) begin
      wbAddr[wbTail_q] <= reqAddr;
      wbData[wbTail_q] <= reqWdata;
      wbBe[wbTail_q] <= reqByteEn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_q <= '0;
      lru_q <= '0;
      state_q <= cache_pkg::IDLE;
      wbHead_q <= 1'b0;
      wbTail_q <= 1'b0;
      wbCount_q <= 2'h0;
      reqReady_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspData_q <= 32'h0;
      busRdReq_q <= 1'b0;
      busRdAddr_q <= 32'h0;
      fillAddr_q <= 32'h0;
      busWrValid_q <= 1'b0;
      busWrAddr_q <= 32'h0;
      busWrData_q <= 32'h0;
      busWrByteEn_q <= 4'h0;
    end else begin
      reqReady_q <= reqReady_d;
      wbCount_q <= wbCount_d;
      if (doWrite) wbTail_q <= ~wbTail_q;
      if (drain) wbHead_q <= ~wbHead_q;
      rspValid_q <= doReadHit || fillDone;
      if (doReadHit) begin
        rspData_q <= dataMem[hitSlot];
        if (twoWay) lru_q[pairIdx] <= hit1;
      end
      if (doWrite && hit && twoWay) lru_q[pairIdx] <= hit1;
      case (state_q)
        cache_pkg::IDLE: begin
          if (doReadMiss) begin
            state_q <= cache_pkg::FILL;
            fillAddr_q <= reqAddr;
            busRdAddr_q <= reqAddr;
            busRdReq_q <= 1'b1;
          end
        end
        cache_pkg::FILL: begin
          if (busRdDone) begin
            busRdReq_q <= 1'b0;
            state_q <= cache_pkg::IDLE;
            rspData_q <= busRdData;
            if (cacheEn) begin
              valid_q[fillSlot] <= 1'b1;
              if (twoWay) lru_q[fillPair] <= victimWay;
            end
          end
        end
        default: state_q <= cache_pkg::IDLE;
      endcase
      // posted write drains independently of the pipeline
      if (!busWrValid_q || busWrDone) begin
        if (wbHasAfter) begin
          busWrValid_q <= 1'b1;
          busWrAddr_q <= doWrite && wbCount_q == 2'(drain) ? reqAddr : wbAddr[headAfter[0]];
          busWrData_q <= doWrite && wbCount_q == 2'(drain) ? reqWdata : wbData[headAfter[0]];
          busWrByteEn_q <= doWrite && wbCount_q == 2'(drain) ? reqByteEn : wbBe[headAfter[0]];
        end else begin
          busWrValid_q <= 1'b0;
        end
      end
    end
  end

  assign reqReady = reqReady_q;
  assign rspValid = rspValid_q;
  assign rspData = rspData_q;
  assign busRdReq = busRdReq_q;
  assign busRdAddr = busRdAddr_q;
  assign busWrValid = busWrValid_q;
  assign busWrAddr = busWrAddr_q;
  assign busWrByteEn = busWrByteEn_q;
  assign busWrData = busWrData_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  AST_WBUF_BOUND: assert property (@(posedge clk) disable iff (rst)
    wbCount_q <= 2'(DEPTH)) else $error("write buffer over two entries");
  AST_STALL_FULL: assert property (@(posedge clk) disable iff (rst)
    wbFull |-> !reqReady_q) else $error("ready while buffer full");
  AST_HIT_ONE: assert property (@(posedge clk) disable iff (rst)
    doReadHit |=> rspValid_q && !busRdReq_q) else $error("hit not answered next cycle");
  AST_NO_WRALLOC: assert property (@(posedge clk) disable iff (rst)
    doWrite && !hit |=> $stable(valid_q)) else $error("write miss allocated");
  AST_MISS_BUS: assert property (@(posedge clk) disable iff (rst)
    doReadMiss |=> busRdReq_q && busRdAddr_q == $past(reqAddr)) else $error("miss no fetch");
  AST_POST: assert property (@(posedge clk) disable iff (rst)
    doWrite && wbCount_q == 2'h0 |=> busWrValid_q) else $error("write not posted");
  AST_DISABLED: assert property (@(posedge clk) disable iff (rst)
    !cacheEn && take && !reqWrite |=> busRdReq_q) else $error("disabled read not sent to bus");
  AST_DM_ONEWAY: assert property (@(posedge clk) disable iff (rst)
    !twoWay && fillDone |-> fillSlot == fillAddr_q[`OFS_BITS +: `IDX_DM_BITS])
    else $error("direct fill in wrong slot");
  AST_WRITE_THROUGH: assert property (@(posedge clk) disable iff (rst)
    doWrite && wbCount_q == 2'h0 |=> busWrAddr_q == $past(reqAddr) && busWrData_q == $past(reqWdata))
    else $error("posted write wrong");
  AST_LRU_HIT: assert property (@(posedge clk) disable iff (rst)
    twoWay && doReadHit |=> lru_q[$past(pairIdx)] == $past(hit1)) else $error("lru not updated");
  AST_WR_LANE0: assert property (@(posedge clk) disable iff (rst)
    doWrite && hit && reqByteEn[0] |=> dataMem[$past(hitSlot)][7:0] == $past(reqWdata[7:0]))
    else $error("write hit lane not updated");
  AST_FILL_DATA: assert property (@(posedge clk) disable iff (rst)
    fillDone |=> rspValid_q && rspData_q == $past(busRdData)) else $error("fill data not returned");
  AST_FILL_RDY: assert property (@(posedge clk) disable iff (rst)
    fillDone |=> reqReady_q || wbFull) else $error("pipeline held after fill");
endmodule : unified_write_through_cache

// ===== hdl/cache_cfg.svh
`ifndef CACHE_CFG_SVH
`define CACHE_CFG_SVH
`define LINE_BYTES 4
`define DM_LINES 256
`define TW_LINES 128
`define WBUF_DEPTH 2
`define OFS_BITS 2
`define IDX_DM_BITS 8
`define IDX_TW_BITS 7
`endif

// ===== hdl/cache_pkg.sv
package cache_pkg;
  typedef enum logic [1:0] {
    IDLE,
    FILL
  } state_t;
endpackage : cache_pkg

// ===== dv/bus_partner.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module bus_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic busRdReq,
  input wire logic [31:0] busRdAddr,
  input wire logic busWrValid,
  input wire logic holdWr,
  output logic busRdDone,
  output logic [31:0] busRdData,
  output logic busWrDone
);
  logic [1:0] rdCnt;
  // address bit 8 selects a slow read, otherwise prompt
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      rdCnt <= 2'h0;
      busRdDone <= 1'b0;
      busWrDone <= 1'b0;
      busRdData <= 32'h0;
    end else begin
      busRdDone <= 1'b0;
      busWrDone <= 1'b0;
      busRdData <= ~busRdData;
      if (busRdReq && !busRdDone) begin
        rdCnt <= rdCnt + 2'h1;
        if (!busRdAddr[8] || rdCnt == 2'h2) begin
          busRdDone <= 1'b1;
          busRdData <= busRdAddr ^ 32'h5A5A0F0F;
          rdCnt <= 2'h0;
        end
      end
      if (busWrValid && !busWrDone && !holdWr) busWrDone <= 1'b1;
    end
  end
endmodule : bus_partner

// ===== dv/unified_write_through_cache_bench.sv
`timescale 1ns/1ps
module unified_write_through_cache_bench;
  logic clk, rst, cacheEn, twoWay, reqValid, reqWrite, holdWr;
  logic reqReady, rspValid, busRdReq, busRdDone, busWrValid, busWrDone;
  logic [31:0] reqAddr, reqWdata, rspData, busRdAddr, busRdData, busWrAddr, busWrData;
  logic [3:0] reqByteEn, busWrByteEn;
  logic [31:0] wrAddrSeen, wrDataSeen, wrBeSeen;
  int failCount, checked, fills, wrDone, cyc;
  unified_write_through_cache dut_u (
    .clk(clk), .rst(rst), .cacheEn(cacheEn), .twoWay(twoWay), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqByteEn(reqByteEn), .reqWdata(reqWdata),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .busRdReq(busRdReq),
    .busRdAddr(busRdAddr), .busRdDone(busRdDone), .busRdData(busRdData),
    .busWrValid(busWrValid), .busWrAddr(busWrAddr), .busWrByteEn(busWrByteEn),
    .busWrData(busWrData), .busWrDone(busWrDone)
  );
  bus_partner partner_u (
    .clk(clk), .rst(rst), .busRdReq(busRdReq), .busRdAddr(busRdAddr),
    .busWrValid(busWrValid), .holdWr(holdWr), .busRdDone(busRdDone),
    .busRdData(busRdData), .busWrDone(busWrDone)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    fills += int'(busRdReq && busRdDone);
    wrDone += int'(busWrValid && busWrDone);
    if (busWrValid && busWrDone) begin
      wrAddrSeen <= busWrAddr;
      wrDataSeen <= busWrData;
      wrBeSeen <= 32'(busWrByteEn);
    end
    if (cyc > 4000) begin
      failCount++;
      summarize();
    end
  end
  function automatic logic [31:0] mv(logic [31:0] a);
    return a ^ 32'h5A5A0F0F;
  endfunction : mv
  task automatic summarize();
    if (failCount == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic check(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic req(logic w, logic [31:0] a, logic [3:0] be, logic [31:0] d);
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqByteEn = be;
    reqWdata = d;
    while (reqReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    reqValid = 1'b0;
  endtask : req
  task automatic rd(logic [31:0] a, logic [31:0] e, int miss);
    int f;
    f = fills;
    req(1'b0, a, 4'hF, 32'h0);
    if (miss == 0) check(32'(rspValid), 32'h1);
    while (rspValid !== 1'b1) @(negedge clk);
    check(rspData, e);
    check(32'(fills - f), 32'(miss));
    @(negedge clk);
    check(32'(rspValid), 32'h0);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic reset_scn(logic tw);
    rst = 1'b1;
    twoWay = tw;
    repeat (8) @(negedge clk);
    check(32'(reqReady), 32'h0);
    check(32'(busWrValid), 32'h0);
    rst = 1'b0;
  endtask : reset_scn
  task automatic disabled_scn();
    rd(32'h100, mv(32'h100), 1);
    rd(32'h100, mv(32'h100), 1);
  endtask : disabled_scn
  task automatic direct_scn();
    cacheEn = 1'b1;
    rd(32'h100, mv(32'h100), 1);
    rd(32'h100, mv(32'h100), 0);
    req(1'b1, 32'h100, 4'h3, 32'h1234ABCD);
    rd(32'h100, (mv(32'h100) & 32'hFFFF0000) | 32'h0000ABCD, 0);
    check(wrAddrSeen, 32'h100);
    check(wrDataSeen, 32'h1234ABCD);
    check(wrBeSeen, 32'h3);
    req(1'b1, 32'h200, 4'hF, 32'h0);
    rd(32'h200, mv(32'h200), 1);
    rd(32'h500, mv(32'h500), 1);
    rd(32'h100, mv(32'h100), 1);
    rd(32'h300, mv(32'h300), 1);
    rd(32'h100, mv(32'h100), 0);
    rd(32'h80000100, mv(32'h80000100), 1);
  endtask : direct_scn
  task automatic stall_scn();
    holdWr <= 1'b1;
    req(1'b1, 32'h10, 4'hF, 32'h1);
    check(32'(reqReady), 32'h1);
    req(1'b1, 32'h14, 4'hF, 32'h2);
    @(negedge clk);
    reqValid = 1'b1;
    reqAddr = 32'h18;
    reqWdata = 32'h3;
    repeat (3) @(negedge clk);
    check(32'(reqReady), 32'h0);
    check(busWrAddr, 32'h10);
    check(busWrData, 32'h1);
    holdWr <= 1'b0;
    while (reqReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    reqValid = 1'b0;
    repeat (12) @(negedge clk);
    check(32'(wrDone), 32'h5);
    check(wrAddrSeen, 32'h18);
    check(wrDataSeen, 32'h3);
  endtask : stall_scn
  task automatic two_way_scn();
    reset_scn(1'b1);
    rd(32'h100, mv(32'h100), 1);
    rd(32'h300, mv(32'h300), 1);
    rd(32'h100, mv(32'h100), 0);
    rd(32'h500, mv(32'h500), 1);
    rd(32'h100, mv(32'h100), 0);
    rd(32'h300, mv(32'h300), 1);
  endtask : two_way_scn
  initial begin
    {cacheEn, twoWay, reqValid, reqWrite} = 4'h0;
    holdWr = 1'b0;
    reqAddr = 32'h0;
    reqByteEn = 4'h0;
    reqWdata = 32'h0;
    reset_scn(1'b0);
    disabled_scn();
    direct_scn();
    stall_scn();
    two_way_scn();
    summarize();
  end
endmodule : unified_write_through_cache_bench
